//--- hw/pitc_core.sv
// Purpose: Proximity interrupt decision, measurement settings and
//          measurement cycle timing of a light and proximity sensor.
// Assumes: The serial bus decoder presents byte accesses on reg_*; the
//          front end pulses prox_conv_done once per finished conversion.
// Notes:   Read data appears one cycle after reg_rd with reg_rvalid.
//
// Notes on behaviour
// R1 - Zone mode: active above upper or below lower
// R2 - Zone: active bumps outside, else bumps inside
// R3 - Outside hits persistence: clear near, raise irq
// R4 - Inside hits persistence: set near, no irq
// R5 - Zero persistence: every conversion counts as active
// R6 - Hysteresis: condition follows target near flag
// R7 - Hysteresis counter bumps on active, else clears
// R8 - Hysteresis hit: flip near, raise irq, clear
// R9 - Idle wait is (code+1) units of 5 ms
// R10 - Ambient gain codes 0-4 map x1..x96
// R11 - Ambient time and maximum count from code
// R12 - Emitter current 50 mA steps per code
// R13 - Pulse width is (code+1) width units
// R14 - Proximity gain two bits, x1 to x8
// R15 - Emitter pulses per measurement are code+1
// R16 - Proximity maximum count is 256(code+1)-1
// R17 - Proximity conversion time from pulses, width, integration
// R18 - Cycle is ambient plus proximity plus wait
// R19 - Persistence register split, resets to 0x11
// R20 - Persistence counts consecutive events; zero means always
// R21 - Irq flag bit 1, style bit 7
// R22 - Irq flag holds until host writes zero
// R23 - Pin enable lets irq flag pull pin low
// R24 - Evaluate once per conversion; reset clears counters
`timescale 1ns/1ps
`default_nettype none

module pitc_core
   import pitc_pkg::*;
#(
   parameter int unsigned AMB_BASE_CYC = AMB_BASE_CYC_DEF,
   parameter int unsigned AMB_STEP_CYC = AMB_STEP_CYC_DEF,
   parameter int unsigned PROX_BASE_CYC = PROX_BASE_CYC_DEF,
   parameter int unsigned PROX_PULSE_FIX_CYC = PROX_PULSE_FIX_CYC_DEF,
   parameter int unsigned PROX_PULSE_UNIT_CYC = PROX_PULSE_UNIT_CYC_DEF,
   parameter int unsigned PROX_INTEG_CYC = PROX_INTEG_CYC_DEF,
   parameter int unsigned WAIT_UNIT_CYC = WAIT_UNIT_CYC_DEF,
   parameter int unsigned RESULT_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic measure_enable,
   input wire logic prox_conv_done,
   input wire logic [RESULT_W-1:0] proximity_result,
   input wire logic [RESULT_W-1:0] proximity_upper_limit,
   input wire logic [RESULT_W-1:0] proximity_lower_limit,
   output logic proximity_irq_flag,
   output logic target_near_flag,
   output logic int_n,
   output pitc_cfg_t cfg,
   output logic ambient_phase,
   output logic proximity_phase,
   output logic wait_phase,
   output logic cycle_start
);

   if (AMB_BASE_CYC == 0 || AMB_STEP_CYC == 0 || PROX_BASE_CYC == 0 ||
       PROX_PULSE_FIX_CYC == 0 || PROX_PULSE_UNIT_CYC == 0 ||
       PROX_INTEG_CYC == 0 || WAIT_UNIT_CYC == 0) begin : g_bad_time
      $error("pitc_core: every timing count must be at least one cycle");
   end
   if (RESULT_W < 12 || RESULT_W > 16) begin : g_bad_width
      $error("pitc_core: RESULT_W must lie between 12 and 16");
   end

   // Register storage.
   logic [7:0] int_control;
   logic [7:0] wait_interval;
   logic [7:0] ambient_gain;
   logic [7:0] ambient_integration;
   logic [7:0] emitter_control;
   logic [7:0] proximity_gain;
   logic [7:0] emitter_pulse_count;
   logic [7:0] proximity_integration;
   logic [7:0] interrupt_persistence;

   // Interrupt decision state.
   logic [3:0] outside_counter;
   logic [3:0] inside_counter;
   logic [3:0] hyst_counter;

   // Sequencer state.
   pitc_seq_t seq_state;
   logic [31:0] phase_timer;

   // Decoded fields.
   logic proximity_trigger_style;
   logic proximity_pin_enable;
   logic [3:0] proximity_repeat_count;
   logic [2:0] ambient_gain_code;
   logic [7:0] ambient_integration_code;
   logic [1:0] emitter_current_code;
   logic [5:0] emitter_width_code;
   logic [1:0] proximity_gain_code;
   logic [7:0] emitter_pulses_code;
   logic [3:0] proximity_integration_code;
   logic [7:0] idle_units;

   logic conv;
   logic above_upper;
   logic below_lower;
   logic active;
   logic [4:0] next_outside;
   logic [4:0] next_inside;
   logic [4:0] next_hyst;
   logic fire_outside;
   logic fire_inside;
   logic fire_hyst;
   logic irq_set;
   logic irq_clear;
   logic wr_en;

   logic [31:0] amb_cycles;
   logic [31:0] prox_cycles;
   logic [31:0] wait_cycles;
   logic [17:0] amb_span;
   pitc_cfg_t next_cfg;

   assign wr_en = ce && reg_wr;
   assign conv = ce && prox_conv_done; // R24

   assign proximity_trigger_style = int_control[TRIGGER_STYLE_BIT]; // R21
   assign proximity_pin_enable = int_control[PIN_ENABLE_BIT];
   assign proximity_repeat_count =
      interrupt_persistence[PRS_PROX_HI:PRS_PROX_LO]; // R19
   assign ambient_gain_code = ambient_gain[AMB_GAIN_HI:0];
   assign ambient_integration_code = ambient_integration;
   assign emitter_current_code =
      emitter_control[EMIT_CURR_HI:EMIT_CURR_LO];
   assign emitter_width_code = emitter_control[EMIT_WIDTH_HI:0];
   assign proximity_gain_code = proximity_gain[PROX_GAIN_HI:0];
   assign emitter_pulses_code = emitter_pulse_count;
   assign proximity_integration_code =
      proximity_integration[PROX_INTEG_HI:0];
   assign idle_units = wait_interval;

   // Register writes; reserved bits are held at zero.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         int_control <= RST_INT_CONTROL;
         wait_interval <= RST_CONFIG;
         ambient_gain <= RST_CONFIG;
         ambient_integration <= RST_CONFIG;
         emitter_control <= RST_CONFIG;
         proximity_gain <= RST_CONFIG; // R14
         emitter_pulse_count <= RST_CONFIG;
         proximity_integration <= RST_CONFIG;
         interrupt_persistence <= RST_PERSISTENCE; // R19
      end else if (wr_en) begin
         case (reg_addr)
            ADDR_INT_CONTROL: int_control <= reg_wdata & INT_CONTROL_MASK;
            ADDR_WAIT_INTERVAL: wait_interval <= reg_wdata;
            ADDR_AMBIENT_GAIN: begin
               ambient_gain <= {5'h00, reg_wdata[AMB_GAIN_HI:0]};
            end
            ADDR_AMBIENT_INTEGRATION: ambient_integration <= reg_wdata;
            ADDR_EMITTER_CONTROL: emitter_control <= reg_wdata;
            ADDR_PROXIMITY_GAIN: begin
               proximity_gain <= {6'h00, reg_wdata[PROX_GAIN_HI:0]};
            end
            ADDR_EMITTER_PULSE_COUNT: emitter_pulse_count <= reg_wdata;
            ADDR_PROXIMITY_INTEGRATION: begin
               proximity_integration <=
                  {4'h0, reg_wdata[PROX_INTEG_HI:0]};
            end
            ADDR_INTERRUPT_PERSISTENCE: interrupt_persistence <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Registered read port; unmapped offsets read zero.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= RST_READ_DATA;
         reg_rvalid <= 1'b0;
      end else if (ce) begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               ADDR_INT_CONTROL: reg_rdata <= int_control;
               ADDR_INT_FLAG: begin
                  reg_rdata <= RST_READ_DATA;
                  reg_rdata[NEAR_FLAG_BIT] <= target_near_flag;
                  reg_rdata[IRQ_FLAG_BIT] <= proximity_irq_flag; // R21
               end
               ADDR_WAIT_INTERVAL: reg_rdata <= wait_interval;
               ADDR_AMBIENT_GAIN: reg_rdata <= ambient_gain;
               ADDR_AMBIENT_INTEGRATION: reg_rdata <= ambient_integration;
               ADDR_EMITTER_CONTROL: reg_rdata <= emitter_control;
               ADDR_PROXIMITY_GAIN: reg_rdata <= proximity_gain;
               ADDR_EMITTER_PULSE_COUNT: reg_rdata <= emitter_pulse_count;
               ADDR_PROXIMITY_INTEGRATION: begin
                  reg_rdata <= proximity_integration;
               end
               ADDR_INTERRUPT_PERSISTENCE: begin
                  reg_rdata <= interrupt_persistence;
               end
               default: reg_rdata <= RST_READ_DATA;
            endcase
         end
      end
   end

   // Active condition and the counters' next values.
   always_comb begin
      above_upper = proximity_result > proximity_upper_limit;
      below_lower = proximity_result < proximity_lower_limit;
      if (proximity_repeat_count == 4'h0) begin
         active = 1'b1; // R5
      end else if (proximity_trigger_style) begin
         active = above_upper || below_lower; // R1
      end else if (target_near_flag) begin
         active = below_lower; // R6
      end else begin
         active = above_upper; // R6
      end
      next_outside = active ? {1'b0, outside_counter} + 5'h01 : 5'h00; // R2
      next_inside = active ? 5'h00 : {1'b0, inside_counter} + 5'h01; // R2
      next_hyst = active ? {1'b0, hyst_counter} + 5'h01 : 5'h00; // R7
      // A count at or past the setting fires, so lowering the setting
      // while a count is in flight cannot strand the counter.
      fire_outside = active && (proximity_repeat_count == 4'h0 ||
         next_outside >= {1'b0, proximity_repeat_count}); // R20
      fire_inside = !active &&
         next_inside >= {1'b0, proximity_repeat_count}; // R4
      fire_hyst = active && (proximity_repeat_count == 4'h0 ||
         next_hyst >= {1'b0, proximity_repeat_count}); // R20
      irq_set = conv &&
         (proximity_trigger_style ? fire_outside : fire_hyst);
      irq_clear = wr_en && reg_addr == ADDR_INT_FLAG &&
         !reg_wdata[IRQ_FLAG_BIT];
   end

   // Persistence counters.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         outside_counter <= 4'h0; // R24
         inside_counter <= 4'h0; // R24
         hyst_counter <= 4'h0; // R24
      end else if (conv) begin
         if (proximity_trigger_style) begin
            outside_counter <= fire_outside ? 4'h0 : next_outside[3:0]; // R3
            inside_counter <= fire_inside ? 4'h0 : next_inside[3:0]; // R4
         end else begin
            hyst_counter <= fire_hyst ? 4'h0 : next_hyst[3:0]; // R8
         end
      end
   end

   // Target near flag.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         target_near_flag <= 1'b0; // R24
      end else if (conv) begin
         if (proximity_trigger_style) begin
            if (fire_outside) begin
               target_near_flag <= 1'b0; // R3
            end else if (fire_inside) begin
               target_near_flag <= 1'b1; // R4
            end
         end else if (fire_hyst) begin
            target_near_flag <= !target_near_flag; // R8
         end
      end
   end

   // Interrupt flag: a new event wins over a clearing write.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         proximity_irq_flag <= 1'b0;
      end else if (irq_set) begin
         proximity_irq_flag <= 1'b1; // R3 R8
      end else if (irq_clear) begin
         proximity_irq_flag <= 1'b0; // R22
      end
   end

   // Interrupt pin.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         int_n <= 1'b1;
      end else if (ce) begin
         int_n <= !(proximity_irq_flag && proximity_pin_enable); // R23
      end
   end

   // Setting decode for the front end and emitter driver.
   always_comb begin
      next_cfg = '0;
      next_cfg.ambient_gain_valid = 1'b1;
      case (ambient_gain_code)
         3'h0: next_cfg.ambient_gain_factor = AMB_GAIN_X1; // R10
         3'h1: next_cfg.ambient_gain_factor = AMB_GAIN_X4;
         3'h2: next_cfg.ambient_gain_factor = AMB_GAIN_X8;
         3'h3: next_cfg.ambient_gain_factor = AMB_GAIN_X32;
         3'h4: next_cfg.ambient_gain_factor = AMB_GAIN_X96;
         default: begin
            next_cfg.ambient_gain_factor = AMB_GAIN_NONE; // R10
            next_cfg.ambient_gain_valid = 1'b0;
         end
      endcase
      amb_span = AMB_COUNT_UNIT * ({10'h000, ambient_integration_code}
         + 18'h00001) - 18'h00001;
      next_cfg.ambient_max_result = (amb_span > AMB_RESULT_CAP) ?
         AMB_RESULT_CAP[15:0] : amb_span[15:0]; // R11
      next_cfg.emitter_current_ma = EMIT_CURR_STEP_MA *
         ({6'h00, emitter_current_code} + 8'h01); // R12
      next_cfg.emitter_width_units =
         {1'b0, emitter_width_code} + 7'h01; // R13
      next_cfg.proximity_gain_factor =
         4'h1 << proximity_gain_code; // R14
      next_cfg.emitter_pulses = {1'b0, emitter_pulses_code} + 9'h001; // R15
      next_cfg.proximity_max_result = PROX_COUNT_UNIT *
         ({8'h00, proximity_integration_code} + 12'h001) - 12'h001; // R16
      next_cfg.idle_units = {1'b0, idle_units} + 9'h001; // R9
      next_cfg.ambient_repeat_count =
         interrupt_persistence[PRS_AMB_HI:PRS_AMB_LO]; // R19
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg <= '0;
      end else if (ce) begin
         cfg <= next_cfg;
      end
   end

   // Phase lengths in clock cycles.
   always_comb begin
      amb_cycles = 32'(AMB_BASE_CYC + AMB_STEP_CYC *
         (32'(ambient_integration_code) + 32'd1)); // R11
      prox_cycles = 32'(PROX_BASE_CYC +
         (32'd2 * (32'(emitter_pulses_code) + 32'd1) + 32'd1) *
         (PROX_PULSE_FIX_CYC + PROX_PULSE_UNIT_CYC *
         (32'(emitter_width_code) + 32'd1)) +
         PROX_INTEG_CYC * (32'(proximity_integration_code) + 32'd1)); // R17
      wait_cycles = 32'(WAIT_UNIT_CYC *
         (32'(idle_units) + 32'd1)); // R9
   end

   // Measurement cycle: ambient, then proximity, then the idle wait.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         seq_state <= PITC_SEQ_IDLE;
         phase_timer <= 32'h0000_0000;
         cycle_start <= 1'b0;
      end else if (ce) begin
         cycle_start <= 1'b0;
         if (!measure_enable) begin
            seq_state <= PITC_SEQ_IDLE;
            phase_timer <= 32'h0000_0000;
         end else begin
            case (seq_state)
               PITC_SEQ_IDLE: begin
                  seq_state <= PITC_SEQ_AMBIENT;
                  phase_timer <= amb_cycles - 32'h0000_0001;
                  cycle_start <= 1'b1;
               end
               PITC_SEQ_AMBIENT: begin
                  if (phase_timer == 32'h0000_0000) begin
                     seq_state <= PITC_SEQ_PROXIMITY; // R18
                     phase_timer <= prox_cycles - 32'h0000_0001;
                  end else begin
                     phase_timer <= phase_timer - 32'h0000_0001;
                  end
               end
               PITC_SEQ_PROXIMITY: begin
                  if (phase_timer == 32'h0000_0000) begin
                     seq_state <= PITC_SEQ_WAIT; // R18
                     phase_timer <= wait_cycles - 32'h0000_0001;
                  end else begin
                     phase_timer <= phase_timer - 32'h0000_0001;
                  end
               end
               PITC_SEQ_WAIT: begin
                  if (phase_timer == 32'h0000_0000) begin
                     seq_state <= PITC_SEQ_AMBIENT; // R18
                     phase_timer <= amb_cycles - 32'h0000_0001;
                     cycle_start <= 1'b1;
                  end else begin
                     phase_timer <= phase_timer - 32'h0000_0001;
                  end
               end
               default: begin
                  seq_state <= PITC_SEQ_IDLE;
                  phase_timer <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   assign ambient_phase = seq_state == PITC_SEQ_AMBIENT;
   assign proximity_phase = seq_state == PITC_SEQ_PROXIMITY;
   assign wait_phase = seq_state == PITC_SEQ_WAIT;

endmodule

`default_nettype wire

//--- pkg/pitc_pkg.sv
// Purpose: Shared constants and types for the proximity interrupt and
//          measurement timing block.
// Assumes: 125 MHz core clock; byte-wide register port.
// Notes:   Times are kept in their own units; cycle counts derive from them.
package pitc_pkg;

   // Register offsets.
   localparam logic [7:0] ADDR_INT_CONTROL = 8'h01;
   localparam logic [7:0] ADDR_INT_FLAG = 8'h02;
   localparam logic [7:0] ADDR_WAIT_INTERVAL = 8'h03;
   localparam logic [7:0] ADDR_AMBIENT_GAIN = 8'h04;
   localparam logic [7:0] ADDR_AMBIENT_INTEGRATION = 8'h05;
   localparam logic [7:0] ADDR_EMITTER_CONTROL = 8'h06;
   localparam logic [7:0] ADDR_PROXIMITY_GAIN = 8'h07;
   localparam logic [7:0] ADDR_EMITTER_PULSE_COUNT = 8'h08;
   localparam logic [7:0] ADDR_PROXIMITY_INTEGRATION = 8'h09;
   localparam logic [7:0] ADDR_INTERRUPT_PERSISTENCE = 8'h0b;

   // Reset values.
   localparam logic [7:0] RST_INT_CONTROL = 8'h03;
   localparam logic [7:0] RST_CONFIG = 8'h00;
   localparam logic [7:0] RST_PERSISTENCE = 8'h11;
   localparam logic [7:0] RST_READ_DATA = 8'h00;

   // Bits 3 and 2 of the interrupt control register are hard zero.
   localparam logic [7:0] INT_CONTROL_MASK = 8'hf3;

   // Field positions.
   localparam int TRIGGER_STYLE_BIT = 7;
   localparam int PIN_ENABLE_BIT = 1;
   localparam int IRQ_FLAG_BIT = 1;
   localparam int NEAR_FLAG_BIT = 5;
   localparam int PRS_PROX_HI = 7;
   localparam int PRS_PROX_LO = 4;
   localparam int PRS_AMB_HI = 3;
   localparam int PRS_AMB_LO = 0;
   localparam int AMB_GAIN_HI = 2;
   localparam int PROX_GAIN_HI = 1;
   localparam int PROX_INTEG_HI = 3;
   localparam int EMIT_CURR_HI = 7;
   localparam int EMIT_CURR_LO = 6;
   localparam int EMIT_WIDTH_HI = 5;

   // Decode tables.
   localparam logic [6:0] AMB_GAIN_X1 = 7'h01;
   localparam logic [6:0] AMB_GAIN_X4 = 7'h04;
   localparam logic [6:0] AMB_GAIN_X8 = 7'h08;
   localparam logic [6:0] AMB_GAIN_X32 = 7'h20;
   localparam logic [6:0] AMB_GAIN_X96 = 7'h60;
   localparam logic [6:0] AMB_GAIN_NONE = 7'h00;
   localparam logic [7:0] EMIT_CURR_STEP_MA = 8'h32;
   localparam logic [17:0] AMB_COUNT_UNIT = 18'h00400;
   localparam logic [17:0] AMB_RESULT_CAP = 18'h0ffff;
   localparam logic [11:0] PROX_COUNT_UNIT = 12'h100;

   // Times, in the units they are specified in.
   localparam real CLK_PERIOD_NS = 8.0;
   localparam real NS_PER_MS = 1.0e6;
   localparam real PROX_TIME_SCALE = 16.0;
   localparam real AMB_BASE_MS = 2.888;
   localparam real AMB_STEP_MS = 2.625;
   localparam real PROX_BASE_MS = 3.051;
   localparam real PROX_PULSE_FIX_MS = 0.01;
   localparam real PROX_PULSE_UNIT_MS = 0.01368;
   localparam real PROX_INTEG_MS = 0.51;
   localparam real WAIT_UNIT_MS = 5.0;

   localparam int unsigned AMB_BASE_CYC_DEF =
      int'(AMB_BASE_MS * NS_PER_MS / CLK_PERIOD_NS);
   localparam int unsigned AMB_STEP_CYC_DEF =
      int'(AMB_STEP_MS * NS_PER_MS / CLK_PERIOD_NS);
   localparam int unsigned PROX_BASE_CYC_DEF =
      int'(PROX_TIME_SCALE * PROX_BASE_MS * NS_PER_MS / CLK_PERIOD_NS);
   localparam int unsigned PROX_PULSE_FIX_CYC_DEF =
      int'(PROX_TIME_SCALE * PROX_PULSE_FIX_MS * NS_PER_MS / CLK_PERIOD_NS);
   localparam int unsigned PROX_PULSE_UNIT_CYC_DEF =
      int'(PROX_TIME_SCALE * PROX_PULSE_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS);
   localparam int unsigned PROX_INTEG_CYC_DEF =
      int'(PROX_TIME_SCALE * PROX_INTEG_MS * NS_PER_MS / CLK_PERIOD_NS);
   localparam int unsigned WAIT_UNIT_CYC_DEF =
      int'(WAIT_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS);

   // Measurement sequencer states.
   typedef enum logic [3:0] {
      PITC_SEQ_IDLE = 4'b0001,
      PITC_SEQ_AMBIENT = 4'b0010,
      PITC_SEQ_PROXIMITY = 4'b0100,
      PITC_SEQ_WAIT = 4'b1000
   } pitc_seq_t;

   // Decoded settings handed to the analog front end and emitter driver.
   typedef struct packed {
      logic [6:0] ambient_gain_factor;
      logic ambient_gain_valid;
      logic [15:0] ambient_max_result;
      logic [7:0] emitter_current_ma;
      logic [6:0] emitter_width_units;
      logic [3:0] proximity_gain_factor;
      logic [8:0] emitter_pulses;
      logic [11:0] proximity_max_result;
      logic [8:0] idle_units;
      logic [3:0] ambient_repeat_count;
   } pitc_cfg_t;

endpackage

//--- tb/pitc_core_monitor.sv
// Purpose: Port-level checks of the proximity interrupt block.
// Assumes: Synchronous active-low reset; all ports in the clk domain.
// Notes: Attached to the core by a bind in the testbench top.
`timescale 1ns/1ps
`default_nettype none
module pitc_core_monitor
   import pitc_pkg::*;
#(
   parameter int unsigned RESULT_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic reg_rvalid,
   input wire logic prox_conv_done,
   input wire logic proximity_irq_flag,
   input wire logic target_near_flag,
   input wire logic int_n,
   input wire pitc_cfg_t cfg,
   input wire logic ambient_phase,
   input wire logic proximity_phase,
   input wire logic wait_phase,
   input wire logic cycle_start
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_read_answer: assert property (ce && reg_rd |=> reg_rvalid)
      else $error("read strobe without rvalid");
   a_irq_sticky: assert property (proximity_irq_flag && !(ce && reg_wr
      && reg_addr == ADDR_INT_FLAG && !reg_wdata[1]) |=> proximity_irq_flag)
      else $error("irq flag dropped without clearing write");
   a_irq_cause: assert property ($rose(proximity_irq_flag)
      |-> $past(prox_conv_done && ce))
      else $error("irq flag rose without a conversion");
   a_near_cause: assert property ($changed(target_near_flag)
      |-> $past(prox_conv_done && ce))
      else $error("near flag moved without a conversion");
   a_pin_cause: assert property (!int_n |-> $past(proximity_irq_flag))
      else $error("interrupt pin low without flag");
   a_cfg_counts: assert property ($past(rst_n) && $past(ce)
      |-> cfg.emitter_pulses != 9'h000 && cfg.idle_units != 9'h000)
      else $error("pulse or idle count decoded as zero");
   a_cfg_limits: assert property ($past(rst_n) && $past(ce)
      |-> cfg.proximity_max_result[7:0] == 8'hff
      && cfg.ambient_max_result[9:0] == 10'h3ff)
      else $error("maximum result decode wrong");
   a_phase_start: assert property (cycle_start |-> ambient_phase)
      else $error("cycle start outside ambient phase");
   a_phase_one: assert property ($onehot0({ambient_phase,
      proximity_phase, wait_phase}))
      else $error("two measurement phases at once");
endmodule
`default_nettype wire

//--- tb/pitc_host.sv
// Purpose: Host side of the byte register port.
// Assumes: Requests change on the falling edge, one cycle long.
// Notes: Read data is taken with rvalid one edge after the strobe.
`timescale 1ns/1ps
`default_nettype none
module pitc_host (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
      @(negedge clk) reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v,
      output logic ok);
      @(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clk) reg_rd = 1'b0;
      v = reg_rdata;
      ok = reg_rvalid;
   endtask
   // Acknowledges an event by writing zero to the irq flag bit.
   task automatic ack();
      wr(8'h02, 8'h00);
   endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: Register and interrupt decision tests of the core.
// Assumes: Ambient timing parameters shortened to 2 cycles each.
// Notes: Clock enable is held high throughout.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pitc_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, me = 1'b0, done = 1'b0, ok, ce = 1'b1;
   logic [15:0] res = 16'h0000, up = 16'h0064, lo = 16'h0032;
   logic [7:0] addr, wd, rdat, d;
   logic wr, rd, rv, irq, near, int_n, cs, ap, pp, wp;
   pitc_cfg_t cfg;
   int n_fail = 0, compares = 0, i, k;
   logic [6:0] gt [5] = '{7'h01, 7'h04, 7'h08, 7'h20, 7'h60};
   initial forever #4 clk = ~clk;
   pitc_core #(.AMB_BASE_CYC(2), .AMB_STEP_CYC(2)) u_dut (.clk(clk),
      .rst_n(rst_n), .ce(ce), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd),
      .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv), .measure_enable(me),
      .prox_conv_done(done), .proximity_result(res),
      .proximity_upper_limit(up), .proximity_lower_limit(lo),
      .proximity_irq_flag(irq), .target_near_flag(near), .int_n(int_n),
      .cfg(cfg), .ambient_phase(ap), .proximity_phase(pp), .wait_phase(wp),
      .cycle_start(cs));
   pitc_host u_host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
      .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv));
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, d, ok);
      chk(16'(ok), 16'h0001);
      chk(16'(d), 16'(e));
   endtask
   task automatic cv(input logic [15:0] r, input logic ei, input logic en);
      @(negedge clk) {done, res} = {1'b1, r};
      @(negedge clk) done = 1'b0;
      chk({15'h0000, irq}, {15'h0000, ei});
      chk({15'h0000, near}, {15'h0000, en});
   endtask
   task automatic test_done();
      $display("checks %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      test_done();
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      rc(8'h01, 8'h03);
      rc(8'h0b, 8'h11);
      for (i = 3; i < 10; i++) rc(8'(i), 8'h00);
      rc(8'h20, 8'h00);
      for (i = 0; i < 5; i++) begin
         u_host.wr(8'h04, 8'(i));
         u_host.wr(8'h06, {i[1:0], 6'h3f});
         u_host.wr(8'h07, {6'h00, i[1:0]});
         @(negedge clk);
         chk(16'(cfg.ambient_gain_factor), 16'(gt[i]));
         chk(16'(cfg.emitter_current_ma), 16'(50 * (i % 4 + 1)));
         chk(16'(cfg.proximity_gain_factor), 16'(1 << (i % 4)));
      end
      u_host.wr(8'h04, 8'hff);
      rc(8'h04, 8'h07);
      u_host.wr(8'h09, 8'hff);
      rc(8'h09, 8'h0f);
      u_host.wr(8'h08, 8'hff);
      u_host.wr(8'h03, 8'hff);
      @(negedge clk);
      chk(16'(cfg.ambient_gain_factor), 16'h0000);
      chk(16'(cfg.proximity_max_result), 16'h0fff);
      chk(16'(cfg.emitter_pulses), 16'h0100);
      chk(16'(cfg.idle_units), 16'h0100);
      chk(16'(cfg.emitter_width_units), 16'h0040);
      chk(16'(cfg.ambient_max_result), 16'h03ff);
      u_host.wr(8'h0b, 8'h21);
      cv(16'd150, 1'b0, 1'b0);
      cv(16'd150, 1'b1, 1'b1);
      @(negedge clk) chk(16'(int_n), 16'h0000);
      cv(16'd10, 1'b1, 1'b1);
      u_host.ack();
      chk(16'(irq), 16'h0000);
      cv(16'd150, 1'b0, 1'b1);
      cv(16'd10, 1'b0, 1'b1);
      cv(16'd10, 1'b1, 1'b0);
      u_host.ack();
      u_host.wr(8'h01, 8'h83);
      u_host.wr(8'h0b, 8'h11);
      cv(16'd200, 1'b1, 1'b0);
      u_host.ack();
      cv(16'd70, 1'b0, 1'b1);
      cv(16'd10, 1'b1, 1'b0);
      u_host.ack();
      u_host.wr(8'h0b, 8'h01);
      cv(16'd70, 1'b1, 1'b0);
      u_host.wr(8'h01, 8'h01);
      u_host.ack();
      cv(16'd70, 1'b1, 1'b1);
      @(negedge clk) chk(16'(int_n), 16'h0001);
      u_host.ack();
      u_host.wr(8'h0b, 8'h21);
      u_host.wr(8'h01, 8'h83);
      cv(16'd200, 1'b0, 1'b1);
      cv(16'd70, 1'b0, 1'b1);
      cv(16'd200, 1'b0, 1'b1);
      cv(16'd200, 1'b1, 1'b0);
      @(negedge clk) me = 1'b1;
      k = 0;
      while (cs !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      chk(16'(ap), 16'h0001);
      k = 0;
      while (ap === 1'b1 && k < 100) begin
         @(negedge clk);
         k++;
      end
      chk(16'(k), 16'd4);
      chk(16'(pp), 16'h0001);
      me = 1'b0;
      test_done();
   end
endmodule
bind pitc_core pitc_core_monitor #(.RESULT_W(RESULT_W)) u_mon (.clk(clk),
   .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
   .prox_conv_done(prox_conv_done), .proximity_irq_flag(proximity_irq_flag),
   .target_near_flag(target_near_flag), .int_n(int_n), .cfg(cfg),
   .ambient_phase(ambient_phase), .proximity_phase(proximity_phase),
   .wait_phase(wait_phase), .cycle_start(cycle_start));
`default_nettype wire
